// ---- common/sync_serial_consts.vh ----
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// Register byte offsets.
`define OFS_MODE        8'h00
`define OFS_CTRL        8'h04
`define OFS_TXD         8'h08
`define OFS_RXD         8'h0c
`define OFS_INTF        8'h10
`define OFS_INTE        8'h14

// Mode register fields.
`define MODE_MASTER_BIT 0
`define MODE_LEN_LSB    8
`define MODE_LEN_MSB    11
`define LEN_RESET       4'h7

// Control register fields.
`define CTRL_EN_BIT     0
`define CTRL_SRST_BIT   1

// Interrupt flag and enable fields.
`define INT_TXE_BIT     0
`define INT_RXF_BIT     1
`define INT_TDONE_BIT   2
`define INT_OVR_BIT     3
`define INTF_BUSY_BIT   7
`define INTF_RESET      4'h1
`define INTE_RESET      4'h0
`define DATA_RESET      16'h0000

// Master serial clock: half period in pclk cycles.
`define HALF_PERIOD     8'h04

`endif

// ---- hdl/pin_sync.v ----
`timescale 1ns/10ps
`default_nettype none

module pin_sync (
	// Clock and reset.
	input  wire       pclk,
	input  wire       presetn,
	// Raw pins and their synchronised copies.
	input  wire [2:0] raw_in,
	output reg  [2:0] sync_out
);

reg [2:0] stage1_r;

// Two flops; only the second stage is read outside.
// Reset values match the idle pins (select high, data high, clock low), so no false edge follows.
always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		stage1_r <= 3'h6;
		sync_out <= 3'h6;
	end else begin
		stage1_r <= raw_in;
		sync_out <= stage1_r;
	end
end

endmodule // pin_sync

`default_nettype wire

// ---- hdl/sync_serial_unit.v ----
// Functional notes
// - In master mode a write to the transmit buffer starts a transfer.
// - A transmit write is accepted whenever tx empty is 1, even mid-shift.
// - Transmit bits above the word length are never sent.
// - Receive buffer is readable when rx full is 1, even while receiving.
// - Receive buffer bits above the word length read as zero.
// - Writing 1 to enable or soft reset clears the receive buffer.
// - Busy bit 7 is 1 during master transfer or slave chip select low.
// - Overrun bit 3 and tx done bit 2 clear only by writing 1 or by soft reset.
// - Rx full bit 1 is read-only and clears on receive buffer read.
// - Tx empty bit 0 is read-only, resets to 1, clears on transmit write.
// - Flags read 1 once their cause occurred: overrun, done, rx full, tx empty.
// - Enable register holds four read/write enables in bits 3..0, reset 0.
// - Tx empty sets when the buffered word moves into the shift register.
// - A received word goes to the buffer, sets rx full; overrun if full.
// - Interrupt request is high while an enabled flag is set.
// - Word length is field plus one bits, reset 0x7; 0x0 is prohibited.
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_consts.vh"

module sync_serial_unit (
	// Clock and reset.
	input  wire        pclk,
	input  wire        presetn,
	// APB slave.
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [7:0]  paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	// Interrupt.
	output reg         irq,
	// Serial pins.
	input  wire        sclk_in,
	output reg         sclk_out,
	output reg         sclk_oe,
	input  wire        serial_in_pin,
	output reg         serial_out_pin,
	output reg         serial_out_oe,
	input  wire        chip_select_in_n
);

////////////////////////////////////////////////////////////////////////////////

function [15:0] len_mask;
	input [3:0] len;
	begin
		len_mask = 16'hffff >> (4'hf - len);
	end
endfunction

function mapped;
	input [7:0] a;
	begin
		mapped = (a == `OFS_MODE) || (a == `OFS_CTRL) || (a == `OFS_TXD) ||
			(a == `OFS_RXD) || (a == `OFS_INTF) || (a == `OFS_INTE);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////

reg  [3:0]  word_length_field_r;
reg         master_r;
reg         channel_enable_r;
reg         soft_reset_bit_r;
reg  [15:0] transmit_data_buffer_r;
reg  [15:0] receive_data_buffer_r;
reg         overrun_flag_r;
reg         tx_done_flag_r;
reg         rx_full_flag_r;
reg         tx_empty_flag_r;
reg  [3:0]  interrupt_enables_r;
reg  [15:0] tx_shift_r;
reg  [15:0] rx_shift_r;
reg  [3:0]  bit_idx_r;
reg         last_bit_r;
reg         active_r;
reg  [7:0]  div_r;
reg         sclk_prev_r;
reg         cs_prev_r;
reg  [31:0] rdata_nxt;
reg         data_valid_r;

wire [2:0]  pins_sync;
wire        sclk_s   = pins_sync[0];
wire        sdi_s    = pins_sync[1];
wire        cs_n_s   = pins_sync[2];

wire        access   = psel & penable & pready;
wire        wr       = access & pwrite;
wire        rd       = access & ~pwrite;
wire        wr_mode  = wr & (paddr == `OFS_MODE);
wire        wr_ctrl  = wr & (paddr == `OFS_CTRL);
wire        wr_txd   = wr & (paddr == `OFS_TXD);
wire        wr_intf  = wr & (paddr == `OFS_INTF);
wire        wr_inte  = wr & (paddr == `OFS_INTE);
wire        rd_rxd   = rd & (paddr == `OFS_RXD);
wire        srst     = wr_ctrl & pwdata[`CTRL_SRST_BIT];
wire        en_wr1   = wr_ctrl & pwdata[`CTRL_EN_BIT];

wire        slave_sel = ~master_r & channel_enable_r & ~cs_n_s;
wire        busy      = master_r ? active_r : slave_sel;
wire        half_done = (div_r == `HALF_PERIOD - 8'h01);
wire        m_tick    = master_r & active_r & half_done;
wire        sample_ev = (m_tick & ~sclk_out) | (slave_sel & sclk_s & ~sclk_prev_r);
wire        shift_ev  = (m_tick & sclk_out) | (slave_sel & ~sclk_s & sclk_prev_r);
wire        cs_fall   = ~master_r & channel_enable_r & ~cs_n_s & cs_prev_r;
wire        m_start   = master_r & channel_enable_r & ~active_r & ~tx_empty_flag_r;
wire [15:0] rx_word   = {rx_shift_r[14:0], sdi_s} & len_mask(word_length_field_r);
wire        word_in   = sample_ev & (bit_idx_r == 4'h0);
wire        word_out  = shift_ev & last_bit_r;
wire        reload    = word_out & ~tx_empty_flag_r;
wire [3:0]  flags     = {overrun_flag_r, tx_done_flag_r, rx_full_flag_r, tx_empty_flag_r};

pin_sync u_pin_sync (
	.pclk     (pclk),
	.presetn  (presetn),
	.raw_in   ({chip_select_in_n, serial_in_pin, sclk_in}),
	.sync_out (pins_sync)
);

////////////////////////////////////////////////////////////////////////////////
// APB slave: one wait state, read data registered with pready.

always @* begin
	rdata_nxt = 32'h0000_0000;
	case (paddr)
	`OFS_MODE: begin
		rdata_nxt[`MODE_LEN_MSB:`MODE_LEN_LSB] = word_length_field_r;
		rdata_nxt[`MODE_MASTER_BIT]            = master_r;
	end
	`OFS_CTRL: begin
		rdata_nxt[`CTRL_EN_BIT]   = channel_enable_r;
		rdata_nxt[`CTRL_SRST_BIT] = soft_reset_bit_r;
	end
	`OFS_TXD:  rdata_nxt[15:0] = transmit_data_buffer_r;
	`OFS_RXD:  rdata_nxt[15:0] = receive_data_buffer_r;
	`OFS_INTF: begin
		rdata_nxt[3:0]            = flags;
		rdata_nxt[`INTF_BUSY_BIT] = busy;
	end
	`OFS_INTE: rdata_nxt[3:0] = interrupt_enables_r;
	default:   rdata_nxt = 32'h0000_0000;
	endcase
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		pready  <= 1'b0;
		pslverr <= 1'b0;
		prdata  <= 32'h0000_0000;
	end else begin
		pready  <= psel & penable & ~pready;
		pslverr <= psel & penable & ~pready & ~mapped(paddr);
		prdata  <= (psel & ~pwrite) ? rdata_nxt : 32'h0000_0000;
	end
end

////////////////////////////////////////////////////////////////////////////////
// Configuration, control and interrupt enables.

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		word_length_field_r <= `LEN_RESET;
		master_r            <= 1'b0;
		channel_enable_r    <= 1'b0;
		soft_reset_bit_r    <= 1'b0;
		interrupt_enables_r <= `INTE_RESET;
		transmit_data_buffer_r <= `DATA_RESET;
	end else begin
		if (wr_mode && !channel_enable_r) begin
			word_length_field_r <= pwdata[`MODE_LEN_MSB:`MODE_LEN_LSB];
			master_r            <= pwdata[`MODE_MASTER_BIT];
		end
		if (wr_ctrl)
			channel_enable_r <= pwdata[`CTRL_EN_BIT];
		soft_reset_bit_r <= srst;
		if (wr_inte)
			interrupt_enables_r <= pwdata[3:0];
		if (wr_txd)
			transmit_data_buffer_r <= pwdata[15:0];
	end
end

////////////////////////////////////////////////////////////////////////////////
// Interrupt flags; a hardware set wins over a software clear.

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		{overrun_flag_r, tx_done_flag_r, rx_full_flag_r, tx_empty_flag_r} <= `INTF_RESET;
	end else if (srst) begin
		{overrun_flag_r, tx_done_flag_r, rx_full_flag_r, tx_empty_flag_r} <= `INTF_RESET;
	end else begin
		if (word_in && rx_full_flag_r && !rd_rxd)
			overrun_flag_r <= 1'b1;
		else if (wr_intf && pwdata[`INT_OVR_BIT])
			overrun_flag_r <= 1'b0;
		if (word_out && tx_empty_flag_r)
			tx_done_flag_r <= 1'b1;
		else if (wr_intf && pwdata[`INT_TDONE_BIT])
			tx_done_flag_r <= 1'b0;
		if (word_in)
			rx_full_flag_r <= 1'b1;
		else if (rd_rxd)
			rx_full_flag_r <= 1'b0;
		if (m_start || reload || (cs_fall && !tx_empty_flag_r))
			tx_empty_flag_r <= 1'b1;
		else if (wr_txd)
			tx_empty_flag_r <= 1'b0;
	end
end

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		irq <= 1'b0;
	else
		irq <= |(flags & interrupt_enables_r);
end

////////////////////////////////////////////////////////////////////////////////
// Receive data buffer.

always @(posedge pclk or negedge presetn) begin
	if (!presetn)
		receive_data_buffer_r <= `DATA_RESET;
	else if (srst || en_wr1)
		receive_data_buffer_r <= `DATA_RESET;
	else if (word_in)
		receive_data_buffer_r <= rx_word;
end

////////////////////////////////////////////////////////////////////////////////
// Shift engine, mode 0, MSB first. Master drives the clock from a divider,
// slave follows the synchronised clock pin while chip select is low.

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		tx_shift_r  <= 16'h0000;
		rx_shift_r  <= 16'h0000;
		bit_idx_r   <= `LEN_RESET;
		last_bit_r  <= 1'b0;
		active_r    <= 1'b0;
		div_r       <= 8'h00;
		sclk_out    <= 1'b0;
		sclk_prev_r <= 1'b0;
		cs_prev_r   <= 1'b1;
	end else begin
		sclk_prev_r <= sclk_s;
		cs_prev_r   <= cs_n_s;
		if (srst || !channel_enable_r) begin
			tx_shift_r <= srst ? 16'h0000 : tx_shift_r;
			rx_shift_r <= 16'h0000;
			bit_idx_r  <= word_length_field_r;
			last_bit_r <= 1'b0;
			active_r   <= 1'b0;
			div_r      <= 8'h00;
			sclk_out   <= 1'b0;
		end else if (m_start) begin
			tx_shift_r <= transmit_data_buffer_r & len_mask(word_length_field_r);
			rx_shift_r <= 16'h0000;
			bit_idx_r  <= word_length_field_r;
			last_bit_r <= 1'b0;
			active_r   <= 1'b1;
			div_r      <= 8'h00;
			sclk_out   <= 1'b0;
		end else if (cs_fall) begin
			if (!tx_empty_flag_r)
				tx_shift_r <= transmit_data_buffer_r & len_mask(word_length_field_r);
			rx_shift_r <= 16'h0000;
			bit_idx_r  <= word_length_field_r;
			last_bit_r <= 1'b0;
		end else begin
			if (master_r && active_r) begin
				div_r <= half_done ? 8'h00 : div_r + 8'h01;
				if (half_done)
					sclk_out <= ~sclk_out;
			end
			if (sample_ev) begin
				rx_shift_r <= word_in ? 16'h0000 : {rx_shift_r[14:0], sdi_s};
				last_bit_r <= (bit_idx_r == 4'h0);
			end
			if (shift_ev) begin
				if (!last_bit_r) begin
					bit_idx_r <= bit_idx_r - 4'h1;
				end else begin
					bit_idx_r  <= word_length_field_r;
					last_bit_r <= 1'b0;
					if (reload)
						tx_shift_r <= transmit_data_buffer_r & len_mask(word_length_field_r);
					else if (master_r)
						active_r <= 1'b0;
				end
			end
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// Pin drivers.

always @(posedge pclk or negedge presetn) begin
	if (!presetn) begin
		serial_out_pin <= 1'b0;
		serial_out_oe  <= 1'b0;
		sclk_oe        <= 1'b0;
		data_valid_r   <= 1'b0;
	end else begin
		data_valid_r   <= (master_r & active_r) | slave_sel;
		serial_out_pin <= data_valid_r ? tx_shift_r[bit_idx_r] : 1'b0;
		serial_out_oe  <= (master_r & channel_enable_r) | slave_sel;
		sclk_oe        <= master_r & channel_enable_r;
	end
end

endmodule // sync_serial_unit

`default_nettype wire

// ---- tb/sync_serial_chk.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_consts.vh"
module sync_serial_chk (
	// Bus side.
	input wire logic        pclk,
	input wire logic        presetn,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [7:0]  paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic        pready,
	input wire logic        pslverr,
	// Interrupt and serial side.
	input wire logic        irq,
	input wire logic        sclk_out,
	input wire logic        sclk_oe,
	input wire logic        serial_out_pin
);
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic [3:0] inte_r;
	wire        xfer_done = psel & penable & pready;
	// Shadow of the enable register, taken from completed bus writes.
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			inte_r <= 4'h0;
		else if (xfer_done && pwrite && paddr == `OFS_INTE)
			inte_r <= pwdata[3:0];
	end
	AST_ONE_WAIT: assert property ($rose(penable) && psel |-> !pready ##1 pready)
		else $error("pready not one cycle after access start");
	AST_PULSE: assert property (pready |=> !pready)
		else $error("pready longer than one cycle");
	AST_SLVERR: assert property (xfer_done && paddr[1:0] == 2'h0 |-> pslverr == (paddr > 8'h14))
		else $error("pslverr wrong for address");
	AST_UPPER_ZERO: assert property (xfer_done && !pwrite |-> prdata[31:16] == 16'h0000)
		else $error("upper read bits not zero");
	AST_INTE_BACK: assert property (xfer_done && !pwrite && paddr == `OFS_INTE |-> prdata[15:0] == {12'h000, inte_r})
		else $error("enable readback wrong");
	AST_IRQ_MASK: assert property (inte_r == 4'h0 && $past(inte_r) == 4'h0 |-> !irq)
		else $error("irq with all enables off");
	AST_SCLK_IDLE: assert property (!sclk_oe |-> !sclk_out)
		else $error("serial clock active while not driven");
	AST_HALF: assert property ($rose(sclk_out) |-> sclk_out[*4] ##1 !sclk_out)
		else $error("serial clock high phase not four cycles");
	AST_SDO_HOLD: assert property (sclk_out && $past(sclk_out) |-> $stable(serial_out_pin))
		else $error("serial data moved while clock high");
	cover property (xfer_done && pwrite && paddr == `OFS_TXD);
	cover property ($rose(irq));
	cover property (xfer_done && pslverr);
endmodule // sync_serial_chk
`default_nettype wire

// ---- tb/spi_peer.sv ----
`timescale 1ns/10ps
`default_nettype none
module spi_peer (
	// Pins coming from the unit.
	input  wire logic        sclk_out,
	input  wire logic        sclk_oe,
	input  wire logic        serial_out_pin,
	// Pins driven towards the unit.
	output var  logic        sclk_in,
	output var  logic        chip_select_in_n,
	output wire logic        serial_in_pin,
	// Captured traffic.
	output var  logic [15:0] got,
	output var  int          edges
);
	logic [15:0] sr = 16'h0000;
	wire         sck = sclk_oe ? sclk_out : sclk_in;
	initial begin
		sclk_in = 1'b0;
		chip_select_in_n = 1'b1;
		got = 16'h0000;
		edges = 0;
	end
	// Outside a frame the line shows the inverse bit, never a stale value.
	assign serial_in_pin = (sclk_oe | ~chip_select_in_n) ? sr[15] : ~sr[15];
	always @(negedge sck) sr <= {sr[14:0], sr[15]};
	always @(posedge sck) begin
		got <= {got[14:0], serial_out_pin};
		edges <= edges + 1;
	end
	task preload(input logic [15:0] v);
		begin
			#1;
			sr = v;
			got = 16'h0000;
			edges = 0;
		end
	endtask
	task frame(input int n);
		begin
			#2;
			chip_select_in_n = 1'b0;
			#125;
			repeat (n) begin
				sclk_in = 1'b1;
				#62.5;
				sclk_in = 1'b0;
				#62.5;
			end
			#125;
			chip_select_in_n = 1'b1;
		end
	endtask
endmodule // spi_peer
`default_nettype wire

// ---- tb/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
`include "sync_serial_consts.vh"
module tb_top;
	logic        pclk = 1'b0;
	logic        presetn = 1'b0;
	logic        psel = 1'b0;
	logic        penable = 1'b0;
	logic        pwrite = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	wire  [31:0] prdata;
	wire         pready, pslverr, irq, sclk_in, sclk_out, sclk_oe;
	wire         serial_in_pin, serial_out_pin, serial_out_oe, chip_select_in_n;
	wire  [15:0] got;
	int          edges;
	logic [31:0] rdata_q;
	logic        err_q;
	int          miscompares = 0;
	int          total_checks = 0;
	always #5 pclk = ~pclk;
	sync_serial_unit dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .sclk_in(sclk_in), .sclk_out(sclk_out),
		.sclk_oe(sclk_oe), .serial_in_pin(serial_in_pin), .serial_out_pin(serial_out_pin),
		.serial_out_oe(serial_out_oe), .chip_select_in_n(chip_select_in_n));
	spi_peer part_u (.sclk_out(sclk_out), .sclk_oe(sclk_oe), .serial_out_pin(serial_out_pin),
		.sclk_in(sclk_in), .chip_select_in_n(chip_select_in_n),
		.serial_in_pin(serial_in_pin), .got(got), .edges(edges));
	task complete_run;
		begin
			if (miscompares == 0 && total_checks > 0)
				$display("STATUS OK");
			else
				$display("STATUS NOT OK");
			$finish;
		end
	endtask
	task chk(input string nm, input logic [31:0] exp, input logic [31:0] seen);
		begin
			total_checks++;
			if (seen !== exp) begin
				miscompares++;
				$display("[ERR] %s expected %h seen %h", nm, exp, seen);
			end
		end
	endtask
	task apb(input logic [7:0] a, input logic w, input logic [31:0] d);
		int n;
		begin
			@(posedge pclk);
			psel <= 1'b1;
			penable <= 1'b0;
			paddr <= a;
			pwrite <= w;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1'b1;
			n = 0;
			do begin
				@(posedge pclk);
				n++;
			end while (pready !== 1'b1 && n < 50);
			chk("pready", 32'h1, {31'h0, pready});
			rdata_q = prdata;
			err_q = pslverr;
			psel <= 1'b0;
			penable <= 1'b0;
		end
	endtask
	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(a, 1'b1, d);
	endtask
	task rd(input string nm, input logic [7:0] a, input logic [31:0] exp);
		begin
			apb(a, 1'b0, 32'h0);
			chk(nm, exp, rdata_q);
		end
	endtask
	task wait_irq;
		int n;
		begin
			n = 0;
			while (irq !== 1'b1 && n < 400) begin
				@(negedge pclk);
				n++;
			end
			chk("irq_wait", 32'h1, {31'h0, irq});
		end
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		rd("len_rst", `OFS_MODE, 32'h0700);
		rd("txd_rst", `OFS_TXD, 32'h0);
		rd("rxd_rst", `OFS_RXD, 32'h0);
		rd("intf_rst", `OFS_INTF, 32'h1);
		rd("inte_rst", `OFS_INTE, 32'h0);
		wr(`OFS_INTE, 32'hffff_ffff);
		rd("inte_rw", `OFS_INTE, 32'hf);
		chk("irq_on", 32'h1, {31'h0, irq});
		wr(`OFS_INTF, 32'hffff_fff0);
		rd("intf_w0", `OFS_INTF, 32'h1);
		apb(8'h18, 1'b1, 32'h1);
		chk("slverr", 32'h1, {31'h0, err_q});
		rd("unmapped", 8'h1c, 32'h0);
		wr(`OFS_INTE, 32'h4);
		repeat (2) @(negedge pclk);
		chk("irq_off", 32'h0, {31'h0, irq});
		wr(`OFS_MODE, 32'h0701);
		wr(`OFS_CTRL, 32'h1);
		part_u.preload(16'ha5c3);
		wr(`OFS_TXD, 32'h3c5a);
		rd("busy", `OFS_INTF, 32'h81);
		chk("sdo_oe_m", 32'h1, {31'h0, serial_out_oe});
		wait_irq;
		chk("sent", 32'h5a, {24'h0, got[7:0]});
		chk("edges", 32'h8, edges);
		rd("flags", `OFS_INTF, 32'h7);
		rd("rxd", `OFS_RXD, 32'ha5);
		rd("rxf_clr", `OFS_INTF, 32'h5);
		wr(`OFS_INTF, 32'h4);
		rd("tdone_clr", `OFS_INTF, 32'h1);
		part_u.preload(16'h1e87);
		wr(`OFS_TXD, 32'h11);
		wr(`OFS_TXD, 32'h22);
		wait_irq;
		chk("sent2", 32'h1122, {16'h0, got});
		rd("ovr", `OFS_INTF, 32'hf);
		rd("rxd2", `OFS_RXD, 32'h87);
		wr(`OFS_INTF, 32'hc);
		rd("ovr_clr", `OFS_INTF, 32'h1);
		wr(`OFS_CTRL, 32'h1);
		rd("rxd_clr", `OFS_RXD, 32'h0);
		wr(`OFS_CTRL, 32'h0);
		wr(`OFS_MODE, 32'h0700);
		wr(`OFS_CTRL, 32'h1);
		wr(`OFS_TXD, 32'hc3);
		part_u.preload(16'h9600);
		fork
			part_u.frame(8);
			begin
				repeat (30) @(posedge pclk);
				rd("slv_busy", `OFS_INTF, 32'h81);
				chk("sdo_oe_f", 32'h1, {31'h0, serial_out_oe});
			end
		join
		chk("slv_sent", 32'hc3, {24'h0, got[7:0]});
		rd("slv_rxd", `OFS_RXD, 32'h96);
		apb(`OFS_INTF, 1'b0, 32'h0);
		chk("slv_idle", 32'h0, {31'h0, rdata_q[7]});
		chk("sdo_oe_s", 32'h0, {31'h0, serial_out_oe});
		wr(`OFS_MODE, 32'h0f01);
		rd("mode_lock", `OFS_MODE, 32'h0700);
		wr(`OFS_CTRL, 32'h2);
		rd("srst_flags", `OFS_INTF, 32'h1);
		rd("srst_rxd", `OFS_RXD, 32'h0);
		rd("srst_ctrl", `OFS_CTRL, 32'h0);
		complete_run;
	end
	initial begin
		#100000;
		miscompares++;
		complete_run;
	end
endmodule // tb_top
bind sync_serial_unit sync_serial_chk chk_u (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
	.pready(pready), .pslverr(pslverr), .irq(irq), .sclk_out(sclk_out), .sclk_oe(sclk_oe),
	.serial_out_pin(serial_out_pin));
`default_nettype wire
